// File: ep_cmd_decoder.sv
`timescale 1ns/1ps
// Contract
// RULE_01: Codes 40-4F stall the low-nibble endpoint; codes 80-8F unstall it.
// RULE_02: A set-up token unstalls a stalled control endpoint, whatever its content.
// RULE_03: Any unstall re-initializes endpoint: buffer flushed, toggle back to DATA0.
// RULE_04: Firmware re-stalls the control endpoint after a set-up token if needed.
// RULE_05: Codes 61-6F mark the selected IN buffer full for the next IN token.
// RULE_06: Validate and clear swap the CPU buffer on double-buffered endpoints.
// RULE_07: Codes 70 and 72-7F empty the selected OUT buffer; 71 is not one.
// RULE_08: A complete OUT packet sets that endpoint's buffer-full flag.
// RULE_09: A full, uncleared OUT endpoint answers further packets with NAK.
// RULE_10: Codes D0-DF return the status byte and clear nothing.
// RULE_11: Status byte: stall, full1, full0, toggle, clobbered, setup, cpu_buffer_select, reserved.
// RULE_12: Set-up overwriting unacknowledged set-up sets clobbered; a later read clears it (code: only a 50-5F clearing read clears it).
// RULE_13: Firmware checks clobbered before ack or stall, abandoning if set.
// RULE_14: Set-up arrival locks control validate and clear until code F4.
// RULE_15: CPU buffer select reads 0 for primary, 1 for secondary.
// RULE_16: Toggle bit reads 0 for DATA0 next, 1 for DATA1 next.
// RULE_17: Codes 50-5F read the status and clear that endpoint's interrupt bit.
// RULE_18: Command phase has A0 high, code on low byte; data phases A0 low.
// RULE_19: Low nibble picks endpoint; action commands have no data phase.
module ep_cmd_decoder
    import ep_cmd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic host_a0_in,
    input wire logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    input wire sie_event_t sie_evt_in,
    output logic [NUM_EP-1:0] ep_stalled_out,
    output logic [NUM_EP-1:0] ep_nak_out,
    output logic [NUM_EP-1:0] ep_in_ready_out,
    output logic [NUM_EP-1:0] ep_toggle_out,
    output logic [NUM_EP-1:0] device_irq_flags_out,
    output logic setup_lock_out
);

    // Whole block state: endpoints, interrupt bits, lock and read phase
    state_t state_r;
    state_t state_nxt;

    // Status byte of one endpoint; bit 0 reads as zero
    function automatic logic [7:0] status_byte(input ep_state_t e);
        logic [7:0] b;
        // Reserved bit 0 keeps its reset level
        b = STATUS_RESET;
        b[ST_STALLED] = e.stalled;
        b[ST_FULL1] = e.full1;
        b[ST_FULL0] = e.full0;
        b[ST_TOGGLE] = e.toggle;       // see RULE_16
        b[ST_CLOBBERED] = e.clobbered;
        b[ST_SETUP] = e.setup_present;
        b[ST_CPU_BUFFER_SELECT] = e.cpu_sel;      // see RULE_15
        return b;                      // see RULE_11
    endfunction

    // Unstall flushes both buffers and restarts the toggle at DATA0
    function automatic ep_state_t reinit(input ep_state_t e);
        ep_state_t r;
        r = e;
        // Clobbered is kept; only a clearing read may remove it
        r.stalled = 1'b0;
        r.full0 = 1'b0;
        r.full1 = 1'b0;
        r.toggle = 1'b0;
        r.cpu_sel = 1'b0;
        r.setup_present = 1'b0;
        return r;                      // see RULE_03
    endfunction

    // Fields of the code byte; the upper lane is never looked at
    logic [7:0] code;
    logic [3:0] grp;
    logic [3:0] cep;
    logic cmd_wr;
    logic data_rd;
    logic ctrl_locked;
    logic evt_ctrl;
    logic out_accept;

    // A0 high marks a command phase, A0 low a data phase
    assign code = host_data_in[7:0];   // Upper byte ignored, see RULE_18
    assign grp = code[7:4];
    assign cep = code[3:0];            // see RULE_19
    assign cmd_wr = host_wr_in && host_a0_in;
    assign data_rd = host_rd_in && !host_a0_in;

    // Validate and clear on the control pair wait for the set-up acknowledge
    assign ctrl_locked = state_r.setup_lock && (cep == EP_CTRL_OUT || cep == EP_CTRL_IN);

    // Engine qualifiers: set-up tokens only count on the control pair, and a
    // packet that met a NAK was never stored
    assign evt_ctrl = (sie_evt_in.ep == EP_CTRL_OUT) || (sie_evt_in.ep == EP_CTRL_IN);
    assign out_accept = sie_evt_in.out_done && !ep_nak_out[sie_evt_in.ep]; // see RULE_09

    // Commands are applied first and engine events after, so a hardware set wins
    always_comb begin
        ep_state_t e;
        logic [3:0] v;
        logic dbl;
        // Locals get a value on every path before use
        e = '0;
        v = '0;
        dbl = 1'b0;
        state_nxt = state_r;

        // Command phase decode; action codes finish at once
        if (cmd_wr) begin
            e = state_r.ep[cep];
            dbl = DBL_EP_MASK[cep];
            state_nxt.phase = PH_IDLE;
            state_nxt.sel_ep = cep;
            // The acknowledge code names no endpoint and only lifts the lock
            if (code == CMD_ACK_SETUP) begin
                state_nxt.setup_lock = 1'b0;                        // see RULE_14
            end else begin
                unique case (grp)
                    // Stall keeps the buffers; only the flag changes
                    GRP_STALL: begin
                        e.stalled = 1'b1;                           // see RULE_01
                    end

                    // Unstall always re-initializes, even a running endpoint
                    GRP_UNSTALL: begin
                        e = reinit(e);                              // see RULE_01
                    end

                    // Validate hands the CPU buffer to the engine for the next IN token
                    GRP_VALIDATE: begin
                        // Control OUT (code 60) is no IN endpoint and is ignored
                        if (IN_EP_MASK[cep] && !ctrl_locked) begin  // see RULE_14
                            if (e.cpu_sel) begin
                                e.full1 = 1'b1;                     // see RULE_05
                            end else begin
                                e.full0 = 1'b1;                     // see RULE_05
                            end
                            // The CPU moves on to the other buffer
                            if (dbl) begin
                                e.cpu_sel = !e.cpu_sel;             // see RULE_06
                            end
                        end
                    end

                    // Clear hands the CPU buffer back to the engine for new packets
                    GRP_CLEAR: begin
                        // Control IN (code 71) is no OUT endpoint and is ignored
                        if (!IN_EP_MASK[cep] && !ctrl_locked) begin // see RULE_07
                            if (e.cpu_sel) begin
                                e.full1 = 1'b0;
                            end else begin
                                e.full0 = 1'b0;
                            end
                            // An emptied buffer no longer holds a set-up packet
                            e.setup_present = 1'b0;
                            // The CPU moves on to the other buffer
                            if (dbl) begin
                                e.cpu_sel = !e.cpu_sel;             // see RULE_06
                            end
                        end
                    end

                    // Status reads only open a phase; side effects wait for the data read
                    GRP_STATUS_CLEARING: begin
                        state_nxt.phase = PH_READ_CLEARING;         // see RULE_17
                    end
                    GRP_STATUS_COPY: begin
                        state_nxt.phase = PH_READ_COPY;             // see RULE_10
                    end

                    default: begin
                        // Codes outside this block are not answered here
                    end
                endcase
            end
            // Write the endpoint back; unchanged for codes that touch nothing
            state_nxt.ep[cep] = e;
        end else if (data_rd) begin
            // Data phase of a status read ends the read
            unique case (state_r.phase)
                PH_READ_CLEARING: begin
                    // Drop the endpoint's interrupt and any latched clobber
                    state_nxt.irq[state_r.sel_ep] = 1'b0;           // see RULE_17
                    state_nxt.ep[state_r.sel_ep].clobbered = 1'b0;  // see RULE_12
                    state_nxt.phase = PH_IDLE;
                end
                PH_READ_COPY: begin
                    // A copy read only closes the phase
                    state_nxt.phase = PH_IDLE;                      // see RULE_10
                end
                PH_IDLE: begin
                    // A stray read with no open phase changes nothing
                end
            endcase
        end

        // Engine events, after the command so that sets win over clears
        v = sie_evt_in.ep;
        e = state_nxt.ep[v];
        dbl = DBL_EP_MASK[v];
        if (out_accept) begin
            // Fill the CPU-side buffer first, else the other one
            if (dbl && (e.cpu_sel ? e.full1 : e.full0)) begin
                if (e.cpu_sel) begin
                    e.full0 = 1'b1;                                 // see RULE_08
                end else begin
                    e.full1 = 1'b1;                                 // see RULE_08
                end
            end else if (dbl && e.cpu_sel) begin
                e.full1 = 1'b1;                                     // see RULE_08
            end else begin
                e.full0 = 1'b1;                                     // see RULE_08
            end
            // Each stored packet advances the expected toggle
            e.toggle = !e.toggle;
            state_nxt.irq[v] = 1'b1;
        end

        // The host took an IN packet, so the engine's buffer is free again
        if (sie_evt_in.in_done) begin
            // The engine sends from the buffer the CPU is not using
            if (dbl && !e.cpu_sel) begin
                e.full1 = 1'b0;
            end else begin
                e.full0 = 1'b0;
            end
            // Each acknowledged packet advances the toggle sent next
            e.toggle = !e.toggle;
            state_nxt.irq[v] = 1'b1;
        end

        // A set-up token overrides a stall so the host can always recover
        if (sie_evt_in.setup_tok && evt_ctrl && e.stalled) begin
            e = reinit(e);                                          // see RULE_02
        end

        // Set-up landed; an earlier one still unacknowledged is now clobbered
        if (sie_evt_in.setup_done) begin
            if (e.setup_present && state_r.setup_lock) begin
                e.clobbered = 1'b1;                                 // see RULE_12
            end
            e.setup_present = 1'b1;
            e.full0 = 1'b1;
            state_nxt.setup_lock = 1'b1;                            // see RULE_14
            state_nxt.irq[v] = 1'b1;
        end

        // Idle cycles write back an unchanged endpoint, so any index is harmless
        state_nxt.ep[v] = e;

        // Status byte follows the selected endpoint live, ready before the read;
        // an event between command and read therefore shows in the byte
        if (state_nxt.phase != PH_IDLE) begin
            state_nxt.rd_data = status_byte(state_nxt.ep[state_nxt.sel_ep]);
        end

        // Reset comes last so that it overrides commands and events alike
        if (srst_in) begin
            state_nxt = '0;
            state_nxt.phase = PH_IDLE;
        end
    end

    // One register stage holds all state; reset is folded into the next value
    always_ff @(posedge core_clk_in) begin
        state_r <= state_nxt;
    end

    // Per-endpoint views for the serial engine
    genvar i;
    generate
        for (i = 0; i < NUM_EP; i++) begin : g_ep
            logic is_in;
            logic is_dbl;
            logic full0;
            logic full1;

            // Fixed endpoint configuration, then the two buffer flags
            assign is_in = IN_EP_MASK[i];
            assign is_dbl = DBL_EP_MASK[i];
            assign full0 = state_r.ep[i].full0;
            assign full1 = state_r.ep[i].full1;

            // An OUT endpoint NAKs when its primary is full if single-buffered, when both are if double; IN endpoints never NAK
            assign ep_nak_out[i] = !is_in && (is_dbl ? (full0 && full1) : full0); // see RULE_09

            // An IN endpoint is ready while any validated buffer waits
            assign ep_in_ready_out[i] = is_in && (full0 || full1); // see RULE_05

            // Stall and toggle straight from the endpoint register
            assign ep_stalled_out[i] = state_r.ep[i].stalled;
            assign ep_toggle_out[i] = state_r.ep[i].toggle; // see RULE_16
        end
    endgenerate

    // Status byte on the low lane; the upper lane always reads zero
    assign host_data_out = {8'h00, state_r.rd_data};

    // Interrupt bits and lock straight from the register
    assign device_irq_flags_out = state_r.irq;
    assign setup_lock_out = state_r.setup_lock;

endmodule

// File: ep_cmd_pkg.sv
package ep_cmd_pkg;

    // Command groups, selected by the high nibble of the code byte
    localparam logic [3:0] GRP_STALL = 4'h4;
    localparam logic [3:0] GRP_STATUS_CLEARING = 4'h5;
    localparam logic [3:0] GRP_VALIDATE = 4'h6;
    localparam logic [3:0] GRP_CLEAR = 4'h7;
    localparam logic [3:0] GRP_UNSTALL = 4'h8;
    localparam logic [3:0] GRP_STATUS_COPY = 4'hd;
    localparam logic [7:0] CMD_ACK_SETUP = 8'hf4;

    // Endpoint indices of the two control endpoints
    localparam logic [3:0] EP_CTRL_OUT = 4'h0;
    localparam logic [3:0] EP_CTRL_IN = 4'h1;
    localparam int NUM_EP = 16;

    // Endpoint configuration: direction and double buffering (plain defaults)
    localparam logic [15:0] IN_EP_MASK = 16'haaaa;
    localparam logic [15:0] DBL_EP_MASK = 16'hfff0;

    // Status byte bit positions
    localparam int ST_STALLED = 7;
    localparam int ST_FULL1 = 6;
    localparam int ST_FULL0 = 5;
    localparam int ST_TOGGLE = 4;
    localparam int ST_CLOBBERED = 3;
    localparam int ST_SETUP = 2;
    localparam int ST_CPU_BUFFER_SELECT = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Events reported by the serial interface engine, at most one per cycle
    typedef struct packed {
        logic out_done;   // Complete OUT packet received, NAKed or not
        logic in_done;    // IN packet sent and acknowledged
        logic setup_tok;  // Set-up token seen on the control endpoint
        logic setup_done; // Set-up data completely written
        logic [3:0] ep;
    } sie_event_t;

    typedef struct packed {
        logic stalled;
        logic full1;
        logic full0;
        logic toggle;
        logic clobbered;
        logic setup_present;
        logic cpu_sel;
    } ep_state_t;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_READ_CLEARING = 3'b010,
        PH_READ_COPY = 3'b100
    } phase_t;

    typedef struct packed {
        ep_state_t [NUM_EP-1:0] ep;
        logic [NUM_EP-1:0] irq;
        logic setup_lock;
        phase_t phase;
        logic [3:0] sel_ep;
        logic [7:0] rd_data;
    } state_t;

endpackage

// File: ep_cmd_decoder_asserts.sv
`timescale 1ns/1ps
module ep_cmd_checker
    import ep_cmd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic host_a0_in,
    input wire logic [15:0] host_data_in,
    input wire sie_event_t sie_evt_in,
    input wire logic [NUM_EP-1:0] ep_stalled_out,
    input wire logic [NUM_EP-1:0] ep_nak_out,
    input wire logic [NUM_EP-1:0] ep_in_ready_out,
    input wire logic [NUM_EP-1:0] ep_toggle_out,
    input wire logic [NUM_EP-1:0] device_irq_flags_out,
    input wire logic setup_lock_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    logic quiet;
    logic cmd;
    logic [3:0] grp;
    logic [3:0] cep;
    logic [3:0] eep;
    logic [3:0] open_grp_r;
    logic [3:0] open_ep_r;
    logic [3:0] cep_r;
    logic [3:0] eep_r;
    // Same-cycle engine events win over commands, so most checks need a quiet engine
    assign quiet = !(sie_evt_in.out_done || sie_evt_in.in_done || sie_evt_in.setup_tok
        || sie_evt_in.setup_done);
    assign cmd = host_wr_in && host_a0_in;
    assign grp = host_data_in[7:4];
    assign cep = host_data_in[3:0];
    assign eep = sie_evt_in.ep;
    // Track which status command opened the read phase, and last endpoints
    always_ff @(posedge core_clk_in) begin
        cep_r <= cep;
        eep_r <= eep;
        if (srst_in) begin
            open_grp_r <= 4'h0;
            open_ep_r <= 4'h0;
        end else if (cmd) begin
            open_grp_r <= grp;
            open_ep_r <= cep;
        end else if (host_rd_in && !host_a0_in) begin
            // A data read closes the phase, so a second read checks nothing
            open_grp_r <= 4'h0;
        end
    end
    sequence s_read;
        host_rd_in && !host_a0_in && !host_wr_in && quiet;
    endsequence
    sequence s_copy_read;
        s_read ##0 (open_grp_r == GRP_STATUS_COPY);
    endsequence
    sequence s_clr_read;
        s_read ##0 (open_grp_r == GRP_STATUS_CLEARING);
    endsequence
    chk_stall_sets: assert property (cmd && grp == GRP_STALL && quiet |=> ep_stalled_out[cep_r])
        else $error("stall command did not stall");
    chk_unstall_init: assert property (cmd && grp == GRP_UNSTALL && quiet
        |=> !ep_stalled_out[cep_r] && !ep_toggle_out[cep_r] && !ep_in_ready_out[cep_r])
        else $error("unstall did not reinitialise endpoint");
    chk_setup_unstall: assert property (sie_evt_in.setup_tok && eep < 4'h2 && !cmd
        |=> !ep_stalled_out[eep_r]) else $error("setup token left endpoint stalled");
    chk_validate_full: assert property (cmd && grp == GRP_VALIDATE && IN_EP_MASK[cep] && quiet
        && !(setup_lock_out && cep < 4'h2) |=> ep_in_ready_out[cep_r])
        else $error("validate did not fill IN buffer");
    chk_out_full_nak: assert property (sie_evt_in.out_done && !ep_nak_out[eep] && !cmd
        && !DBL_EP_MASK[eep] && !IN_EP_MASK[eep] |=> ep_nak_out[eep_r] && device_irq_flags_out[eep_r])
        else $error("complete OUT packet did not fill buffer");
    chk_nak_refuse: assert property (sie_evt_in.out_done && ep_nak_out[eep] && !cmd
        |=> $stable(ep_toggle_out) && ep_nak_out[eep_r]) else $error("packet accepted while NAK");
    chk_setup_locks: assert property (sie_evt_in.setup_done && eep < 4'h2 |=> setup_lock_out)
        else $error("setup data did not lock commands");
    chk_ack_unlocks: assert property (cmd && host_data_in[7:0] == CMD_ACK_SETUP && quiet
        |=> !setup_lock_out) else $error("acknowledge did not unlock");
    chk_copy_keeps: assert property (s_copy_read |=> $stable(device_irq_flags_out))
        else $error("copy read changed interrupt bits");
    chk_clear_read: assert property (s_clr_read |=> !device_irq_flags_out[open_ep_r])
        else $error("clearing read left interrupt bit");
endmodule
bind ep_cmd_decoder ep_cmd_checker u_chk (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .host_wr_in(host_wr_in), .host_rd_in(host_rd_in), .host_a0_in(host_a0_in),
    .host_data_in(host_data_in), .sie_evt_in(sie_evt_in), .ep_stalled_out(ep_stalled_out),
    .ep_nak_out(ep_nak_out), .ep_in_ready_out(ep_in_ready_out), .ep_toggle_out(ep_toggle_out),
    .device_irq_flags_out(device_irq_flags_out), .setup_lock_out(setup_lock_out));

// File: usb_sie_model.sv
`timescale 1ns/1ps
module usb_sie_model
    import ep_cmd_pkg::*;
(
    input wire logic clk_in,
    output sie_event_t evt_out
);
    initial evt_out = '0;
    // One-cycle event; idle endpoint field is scrambled so stale values are never trusted
    task automatic send(input int kind, input logic [3:0] ep);
        @(negedge clk_in);
        evt_out = '0;
        evt_out.ep = ep;
        case (kind)
            0: evt_out.out_done = 1'b1; // Only whole packets are reported
            1: evt_out.in_done = 1'b1;
            2: evt_out.setup_tok = 1'b1;
            default: evt_out.setup_done = 1'b1; // Raised once data is all written
        endcase
        @(negedge clk_in);
        evt_out = '0;
        evt_out.ep = ~ep;
    endtask
endmodule

// File: usb_endpoint_buffer_commands_tb.sv
`timescale 1ns/1ps
module usb_endpoint_buffer_commands_tb
    import ep_cmd_pkg::*;
;
    logic clk, srst, wr, rd, a0, lock;
    logic [15:0] din, dout, stalled, nak, ready, toggle, irq;
    sie_event_t evt;
    int bad_count, compares, i;
    ep_cmd_decoder dut (.core_clk_in(clk), .srst_in(srst), .host_wr_in(wr), .host_rd_in(rd),
        .host_a0_in(a0), .host_data_in(din), .host_data_out(dout), .sie_evt_in(evt),
        .ep_stalled_out(stalled), .ep_nak_out(nak), .ep_in_ready_out(ready),
        .ep_toggle_out(toggle), .device_irq_flags_out(irq), .setup_lock_out(lock));
    usb_sie_model sie (.clk_in(clk), .evt_out(evt));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Command phase; upper byte carries junk because it must be ignored
    task cmd(input logic [7:0] code);
        @(negedge clk);
        wr = 1'b1;
        a0 = 1'b1;
        din = {8'ha5, code};
        @(negedge clk);
        wr = 1'b0;
        din = ~din;
    endtask
    task status(input logic [7:0] code, input logic [7:0] exp);
        cmd(code);
        check("status", dout, {8'h00, exp});
        @(negedge clk);
        rd = 1'b1;
        a0 = 1'b0;
        @(negedge clk);
        rd = 1'b0;
    endtask
    task tally_and_finish;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        a0 = 1'b0;
        din = 16'h0000;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        status(8'hd2, 8'h00);
        for (i = 0; i < 16; i++) cmd(8'h40 + 8'(i));
        check("stalled", stalled, 16'hffff);
        status(8'hd5, 8'h80);
        for (i = 0; i < 16; i++) cmd(8'h80 + 8'(i));
        check("stalled", stalled, 16'h0000);
        sie.send(0, 4'h2);
        check("nak", nak, 16'h0004);
        check("toggle", toggle, 16'h0004);
        sie.send(0, 4'h2);
        status(8'hd2, 8'h30);
        check("irq", irq, 16'h0004);
        cmd(8'h72);
        check("nak", nak, 16'h0000);
        status(8'h52, 8'h10);
        check("irq", irq, 16'h0000);
        cmd(8'h65);
        check("ready", ready, 16'h0020);
        status(8'hd5, 8'h22);
        sie.send(1, 4'h5);
        status(8'hd5, 8'h12);
        cmd(8'h45);
        cmd(8'h85);
        status(8'hd5, 8'h00);
        // Control endpoint: stalled, then a set-up arrives twice before acknowledge
        cmd(8'h40);
        sie.send(2, 4'h0);
        check("stalled", stalled, 16'h0000);
        cmd(8'h40); // Firmware keeps it stalled
        check("stalled", stalled, 16'h0001);
        sie.send(2, 4'h0);
        check("stalled", stalled, 16'h0000);
        sie.send(3, 4'h0);
        check("lock", {15'h0000, lock}, 16'h0001);
        cmd(8'h61);
        check("ready", ready, 16'h0000);
        sie.send(3, 4'h0);
        status(8'hd0, 8'h2c);
        status(8'h50, 8'h2c); // Firmware sees the flag and restarts
        status(8'hd0, 8'h24);
        cmd(8'hf4);
        check("lock", {15'h0000, lock}, 16'h0000);
        cmd(8'h61);
        check("ready", ready, 16'h0002);
        tally_and_finish;
    end
    // The tests take about 150 cycles; this cuts a hang short
    initial begin
        #20000;
        bad_count++;
        tally_and_finish;
    end
endmodule
